// ==== isc_pkg.sv ====
// constants for the interrupt status collector
package isc_pkg;
  localparam int ISC_AW = 8;
  localparam logic [ISC_AW-1:0] ISC_STATUS_OFS = 8'h58;
  localparam logic [ISC_AW-1:0] ISC_BYTE_TEST_OFS = 8'h64;
  localparam logic [31:0] ISC_STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] ISC_UNMAPPED_READ = 32'h0000_0000;
  // status bit positions
  localparam int ISC_B_SW = 31;
  localparam int ISC_B_TXHALT = 25;
  localparam int ISC_B_RXHALT = 24;
  localparam int ISC_B_DROPHALF = 23;
  localparam int ISC_B_LOADED = 21;
  localparam int ISC_B_RXXFER = 20;
  localparam int ISC_B_TIMER = 19;
  localparam int ISC_B_LINE = 18;
  localparam int ISC_B_POWER = 17;
  localparam int ISC_B_TRANSMIT_STATUS_OVERFLOW_FLAG = 16;
  localparam int ISC_B_RXWD = 15;
  localparam int ISC_B_RXERR = 14;
  localparam int ISC_B_TXERR = 13;
  localparam int ISC_B_TXOVR = 10;
  localparam int ISC_B_TXAVAIL = 9;
  localparam int ISC_B_TSFULL = 8;
  localparam int ISC_B_TSLEVEL = 7;
  localparam int ISC_B_DROP = 6;
  localparam int ISC_B_RSFULL = 4;
  localparam int ISC_B_RSLEVEL = 3;
  localparam int ISC_B_PIN_LO = 0;
  localparam int ISC_PIN_N = 3;
  // write-one-clear bits; bit 18 and reserved bits excluded
  localparam logic [31:0] ISC_WC_MASK = 32'h83bb_e7df;
  // level thresholds in the fifo level configuration word
  localparam int ISC_TXAVAIL_THR_LO = 24;
  localparam int ISC_TSLEVEL_THR_LO = 16;
  localparam int ISC_RSLEVEL_THR_LO = 0;
  localparam int ISC_THR_W = 8;
  localparam int ISC_BLOCK_SHIFT = 6;
  localparam logic [15:0] ISC_RX_LEN_LIMIT = 16'h0800;
  localparam logic [31:0] ISC_DROP_BEFORE = 32'h7fff_ffff;
  localparam logic [31:0] ISC_DROP_AFTER = 32'h8000_0000;
  localparam logic [15:0] ISC_TIMER_BEFORE = 16'h0000;
  localparam logic [15:0] ISC_TIMER_AFTER = 16'hffff;
  typedef struct packed {
    logic [31:0] status;
    logic [31:0] drop_prev;
    logic [15:0] timer_prev;
    logic prev_ok;
    logic [31:0] rdata;
    logic wake;
  } isc_state_t;
endpackage

// ==== isc_collector.sv ====
// interrupt status word with write-one-clear acknowledge
// Summary of operation
// - writing one to a writable status bit clears it; zero leaves it
// - bit 31 sets while software request enable is high; one clears it
// - bit 25 sets when transmit stop is requested and transmitter halted
// - bit 24 sets when the receive engine reports it has halted
// - bit 23 sets when drop counter steps 7fffffff to 80000000
// - bit 21 sets when a notify-flagged buffer is fully loaded
// - bit 20 sets when programmed receive transfer count has moved out
// - bit 19 sets when the general timer wraps from zero to ffff
// - bit 18 is read-only, mirrors line interface event, ignores writes
// - bit 17 sets on power event regardless of wake pin; one clears
// - only a host write to byte test register wakes the device
// - power event interrupt bypasses the deassertion hold-off interval
// - bit 16 sets when the transmit status queue overflows
// - bit 15 sets when a received packet exceeds 2048 bytes
// - bit 14 sets when the receive engine signals an error
// - bit 13 sets when the transmit engine signals an error
// - bit 10 sets on a transmit data write while that queue is full
// - bit 9 sets when transmit free space exceeds the threshold
// - bit 8 on transmit status full; bit 7 above its level threshold
// - bit 6 sets every time a received frame is dropped
// - bit 4 on receive status full; bit 3 above its level threshold
// - bits 2 to 0 capture general pin events; one clears each
// - master indication high when any enabled status bit is set
// - status bits record events regardless of the enable mask
// - free space threshold in bits 31-24 in 64-byte blocks
`timescale 1ns/100ps
`default_nettype none
module isc_collector
  import isc_pkg::*;
#(
  parameter int FREE_W = 14,
  parameter int WORDS_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // host register access
  input wire logic host_cs,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [isc_pkg::ISC_AW-1:0] host_addr,
  input wire logic [31:0] host_wdata,
  output logic [31:0] host_rdata,
  // configuration from neighbouring registers
  input wire logic [31:0] int_enable,
  input wire logic [31:0] fifo_level_cfg,
  input wire logic software_request_enable,
  input wire logic transmit_stop_request,
  // transmit side events
  input wire logic transmitter_halted,
  input wire logic buffer_loaded,
  input wire logic transmit_error,
  input wire logic tx_data_write,
  input wire logic tx_data_full,
  input wire logic [FREE_W-1:0] tx_free_bytes,
  input wire logic tx_status_overflow,
  input wire logic tx_status_full,
  input wire logic [WORDS_W-1:0] tx_status_words,
  // receive side events
  input wire logic receiver_halted,
  input wire logic receive_transfer_done,
  input wire logic receive_error,
  input wire logic rx_frame_done,
  input wire logic [15:0] rx_frame_len,
  input wire logic frame_dropped,
  input wire logic [31:0] rx_drop_count,
  input wire logic rx_status_full,
  input wire logic [WORDS_W-1:0] rx_status_words,
  // other sources
  input wire logic [15:0] timer_value,
  input wire logic line_interface_irq,
  input wire logic power_event,
  input wire logic [isc_pkg::ISC_PIN_N-1:0] general_pin_events,
  // results
  output logic [31:0] interrupt_status,
  output logic master_irq,
  output logic power_event_irq,
  output logic device_wake
);
  import isc_pkg::*;

  isc_state_t st_r;
  isc_state_t st_nxt;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic status_wr;
  logic status_rd;
  logic wake_wr;
  logic [ISC_THR_W-1:0] tx_blocks;

  function automatic logic level_over(input logic [WORDS_W-1:0] used,
                                      input logic [ISC_THR_W-1:0] thr);
    level_over = 32'(used) > 32'(thr);
  endfunction

  assign status_wr = host_cs && host_wr && host_addr == ISC_STATUS_OFS;
  assign status_rd = host_cs && host_rd;
  // any data written here counts, the value itself is ignored
  assign wake_wr = host_cs && host_wr && host_addr == ISC_BYTE_TEST_OFS;
  assign tx_blocks = ISC_THR_W'(tx_free_bytes >> ISC_BLOCK_SHIFT);

  always_comb begin
    set_vec = '0;
    set_vec[ISC_B_SW] = software_request_enable;
    set_vec[ISC_B_TXHALT] = transmit_stop_request && transmitter_halted;
    set_vec[ISC_B_RXHALT] = receiver_halted;
    // needs a valid previous sample so reset does not fake a crossing
    set_vec[ISC_B_DROPHALF] = st_r.prev_ok
      && st_r.drop_prev == ISC_DROP_BEFORE
      && rx_drop_count == ISC_DROP_AFTER;
    set_vec[ISC_B_LOADED] = buffer_loaded;
    set_vec[ISC_B_RXXFER] = receive_transfer_done;
    set_vec[ISC_B_TIMER] = st_r.prev_ok
      && st_r.timer_prev == ISC_TIMER_BEFORE
      && timer_value == ISC_TIMER_AFTER;
    set_vec[ISC_B_POWER] = power_event;
    set_vec[ISC_B_TRANSMIT_STATUS_OVERFLOW_FLAG] = tx_status_overflow;
    set_vec[ISC_B_RXWD] = rx_frame_done
      && rx_frame_len > ISC_RX_LEN_LIMIT;
    set_vec[ISC_B_RXERR] = receive_error;
    set_vec[ISC_B_TXERR] = transmit_error;
    set_vec[ISC_B_TXOVR] = tx_data_write && tx_data_full;
    set_vec[ISC_B_TXAVAIL] = tx_blocks >
      fifo_level_cfg[ISC_TXAVAIL_THR_LO +: ISC_THR_W];
    set_vec[ISC_B_TSFULL] = tx_status_full;
    set_vec[ISC_B_TSLEVEL] = level_over(tx_status_words,
      fifo_level_cfg[ISC_TSLEVEL_THR_LO +: ISC_THR_W]);
    set_vec[ISC_B_DROP] = frame_dropped;
    set_vec[ISC_B_RSFULL] = rx_status_full;
    set_vec[ISC_B_RSLEVEL] = level_over(rx_status_words,
      fifo_level_cfg[ISC_RSLEVEL_THR_LO +: ISC_THR_W]);
    set_vec[ISC_B_PIN_LO +: ISC_PIN_N] = general_pin_events;
  end

  // bit 18 and reserved bits are outside the clear mask
  assign clr_vec = status_wr ? (host_wdata & ISC_WC_MASK) : '0;

  always_comb begin
    st_nxt = st_r;
    // events are recorded whatever the enables say
    st_nxt.status = ((st_r.status & ~clr_vec) | set_vec)
      & ISC_WC_MASK;
    st_nxt.status[ISC_B_LINE] = line_interface_irq;
    st_nxt.drop_prev = rx_drop_count;
    st_nxt.timer_prev = timer_value;
    st_nxt.prev_ok = 1'b1;
    if (status_rd) begin
      st_nxt.rdata = host_addr == ISC_STATUS_OFS ? st_r.status
        : ISC_UNMAPPED_READ;
    end
    st_nxt.wake = wake_wr;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r.status <= ISC_STATUS_RST;
      st_r.drop_prev <= '0;
      st_r.timer_prev <= '0;
      st_r.prev_ok <= 1'b0;
      st_r.rdata <= '0;
      st_r.wake <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign host_rdata = st_r.rdata;
  assign interrupt_status = st_r.status;
  // enable mask gates only the summary and power event outputs, never the status bits
  assign master_irq = |(st_r.status & int_enable);
  // taken straight from the flag, no hold-off timer in the path
  assign power_event_irq = st_r.status[ISC_B_POWER]
    && int_enable[ISC_B_POWER];
  assign device_wake = st_r.wake;

  clear_write_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    status_wr && host_wdata[ISC_B_TXERR] && !transmit_error
    |=> !interrupt_status[ISC_B_TXERR])
    else $error("write one did not clear bit 13");

  zero_write_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    interrupt_status[ISC_B_RXERR] && status_wr && !host_wdata[ISC_B_RXERR]
    |=> interrupt_status[ISC_B_RXERR])
    else $error("write zero changed bit 14");

  sw_request_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    software_request_enable |=> interrupt_status[ISC_B_SW])
    else $error("software request flag not set");

  tx_halt_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !(transmit_stop_request && transmitter_halted)
      && !interrupt_status[ISC_B_TXHALT]
    |=> !interrupt_status[ISC_B_TXHALT])
    else $error("transmit halted flag set without cause");

  drop_half_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    $past(rx_drop_count) == ISC_DROP_BEFORE
      && rx_drop_count == ISC_DROP_AFTER && !$past(sys_rst)
    |=> interrupt_status[ISC_B_DROPHALF])
    else $error("drop counter halfway missed");

  timer_wrap_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    $past(timer_value) == ISC_TIMER_BEFORE
      && timer_value == ISC_TIMER_AFTER && !$past(sys_rst)
    |=> interrupt_status[ISC_B_TIMER])
    else $error("timer wrap missed");

  line_mirror_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    1'b1 |=> interrupt_status[ISC_B_LINE] == $past(line_interface_irq))
    else $error("line interface bit does not follow source");

  wake_only_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !wake_wr |=> !device_wake)
    else $error("wake without byte test write");

  power_irq_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    power_event && int_enable[ISC_B_POWER]
      ##1 int_enable[ISC_B_POWER] |-> power_event_irq)
    else $error("power event interrupt delayed");

  watchdog_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    rx_frame_done && rx_frame_len == 16'h0801
    |=> interrupt_status[ISC_B_RXWD])
    else $error("long packet not flagged");

  master_irq_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    transmit_error ##1 int_enable[ISC_B_TXERR] |-> master_irq)
    else $error("enabled event missing from master");

  set_wins_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    frame_dropped && status_wr && host_wdata[ISC_B_DROP]
    |=> interrupt_status[ISC_B_DROP])
    else $error("event lost against clear");

  reserved_zero_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    status_wr |=> (interrupt_status & ~ISC_WC_MASK
      & ~(32'h1 << ISC_B_LINE)) == 32'h0)
    else $error("reserved status bit set");

  reset_clear_a: assert property (
    @(posedge clk)
    sys_rst |=> interrupt_status == ISC_STATUS_RST && !device_wake)
    else $error("status not cleared by reset");

  tx_halt_set_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    transmit_stop_request && transmitter_halted
    |=> interrupt_status[ISC_B_TXHALT])
    else $error("transmit halted flag missed");

  rx_halt_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    receiver_halted |=> interrupt_status[ISC_B_RXHALT])
    else $error("receive halted flag missed");

  buffer_loaded_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    buffer_loaded |=> interrupt_status[ISC_B_LOADED])
    else $error("buffer loaded flag missed");

  rx_transfer_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    receive_transfer_done |=> interrupt_status[ISC_B_RXXFER])
    else $error("receive transfer flag missed");

  power_flag_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    power_event |=> interrupt_status[ISC_B_POWER])
    else $error("power event flag missed");

  power_clear_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    status_wr && host_wdata[ISC_B_POWER] && !power_event
    |=> !interrupt_status[ISC_B_POWER])
    else $error("write one did not clear bit 17");

  tx_overflow_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    tx_status_overflow |=> interrupt_status[ISC_B_TRANSMIT_STATUS_OVERFLOW_FLAG])
    else $error("status queue overflow missed");

  rx_error_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    receive_error |=> interrupt_status[ISC_B_RXERR])
    else $error("receive error flag missed");

  tx_overrun_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    tx_data_write && tx_data_full |=> interrupt_status[ISC_B_TXOVR])
    else $error("transmit data overrun missed");

  pin_event_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    general_pin_events != '0 |=> (interrupt_status[ISC_B_PIN_LO +: ISC_PIN_N]
      & $past(general_pin_events)) == $past(general_pin_events))
    else $error("general pin event missed");
endmodule
`default_nettype wire

// ==== isc_host_model.sv ====
// host processor model for the status register bus
`timescale 1ns/100ps
`default_nettype none
module isc_host_model (
  // clock
  input wire logic clk,
  // register bus
  output logic host_cs,
  output logic host_wr,
  output logic host_rd,
  output logic [isc_pkg::ISC_AW-1:0] host_addr,
  output logic [31:0] host_wdata,
  input wire logic [31:0] host_rdata
);
  import isc_pkg::*;
  initial begin
    host_cs = 1'b0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 8'h00;
    host_wdata = 32'h0;
  end
  // released address and data lines show inverted values so stale data never looks valid; select and strobes go low
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk);
    host_cs <= 1'b1;
    host_wr <= w;
    host_rd <= ~w;
    host_addr <= a;
    host_wdata <= d;
    @(posedge clk);
    host_cs <= 1'b0;
    host_wr <= 1'b0;
    host_rd <= 1'b0;
    host_addr <= ~a;
    host_wdata <= ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  // read data is registered, so it is taken once the taking edge has passed
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0);
    @(negedge clk);
    d = host_rdata;
  endtask
endmodule
`default_nettype wire

// ==== interrupt_status_collector_tb.sv ====
// self-checking bench for the interrupt status collector
`timescale 1ns/100ps
`default_nettype none
module interrupt_status_collector_tb;
  import isc_pkg::*;
  // single-cycle sources, indexed by their status bit
  localparam logic [31:0] EV_BITS = 32'h8133_6157;
  logic clk, sys_rst, host_cs, host_wr, host_rd;
  logic master_irq, power_event_irq, device_wake;
  logic [7:0] host_addr, tx_status_words, rx_status_words;
  logic [31:0] host_wdata, host_rdata, int_enable, fifo_level_cfg, ev;
  logic [31:0] rx_drop_count, interrupt_status, d;
  logic [13:0] tx_free_bytes;
  logic [15:0] rx_frame_len, timer_value;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc_n = 0;
  isc_host_model u_host (.clk, .host_cs, .host_wr, .host_rd, .host_addr,
    .host_wdata, .host_rdata);
  isc_collector u_dut (.clk, .sys_rst, .host_cs, .host_wr, .host_rd,
    .host_addr, .host_wdata, .host_rdata, .int_enable, .fifo_level_cfg,
    .software_request_enable(ev[31]), .transmit_stop_request(ev[25]),
    .transmitter_halted(ev[26]), .buffer_loaded(ev[21]),
    .transmit_error(ev[13]), .tx_data_write(ev[10]),
    .tx_data_full(ev[11]), .tx_free_bytes,
    .tx_status_overflow(ev[16]), .tx_status_full(ev[8]),
    .tx_status_words, .receiver_halted(ev[24]),
    .receive_transfer_done(ev[20]), .receive_error(ev[14]),
    .rx_frame_done(ev[15]), .rx_frame_len, .frame_dropped(ev[6]),
    .rx_drop_count, .rx_status_full(ev[4]), .rx_status_words,
    .timer_value, .line_interface_irq(ev[18]), .power_event(ev[17]),
    .general_pin_events(ev[2:0]), .interrupt_status, .master_irq,
    .power_event_irq, .device_wake);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic look(input string n, input logic [31:0] e);
    @(negedge clk);
    chk(n, e, interrupt_status);
  endtask
  // clears all writable bits; level causes must be gone first or bits re-set
  task automatic see(input string n, input logic [31:0] e);
    look(n, e);
    u_host.wr(ISC_STATUS_OFS, 32'hffff_ffff);
  endtask
  task automatic hit(input logic [31:0] m);
    @(posedge clk) ev <= m;
    @(posedge clk) ev <= 32'h0;
  endtask
  task automatic t_bits;
    for (int i = 0; i < 32; i++) begin
      if (EV_BITS[i]) begin
        hit(32'h1 << i);
        u_host.rd(ISC_STATUS_OFS, d);
        chk("read", 32'h1 << i, d);
        u_host.wr(ISC_STATUS_OFS, ~(32'h1 << i));
        look("keep", 32'h1 << i);
        see("set", 32'h1 << i);
        look("clear", 32'h0);
      end
    end
  endtask
  task automatic t_cond;
    hit(32'h1 << 25);
    see("stop", 32'h0);
    hit(32'h3 << 25);
    see("stop", 32'h1 << 25);
    hit(32'h1 << 10);
    see("ovr", 32'h0);
    hit(32'h3 << 10);
    see("ovr", 32'h1 << 10);
    rx_frame_len <= 16'h0800;
    hit(32'h1 << 15);
    see("wd", 32'h0);
    rx_frame_len <= 16'h0801;
    hit(32'h1 << 15);
    see("wd", 32'h1 << 15);
  endtask
  task automatic t_count;
    @(posedge clk) rx_drop_count <= 32'h7fff_fffe;
    @(posedge clk) rx_drop_count <= 32'h7fff_ffff;
    @(posedge clk) timer_value <= 16'h0001;
    @(posedge clk) timer_value <= 16'h0000;
    @(posedge clk);
    look("step", 32'h0);
    @(posedge clk) rx_drop_count <= 32'h8000_0000;
    @(posedge clk) timer_value <= 16'hffff;
    @(posedge clk);
    see("wrap", 32'h0088_0000);
  endtask
  // thresholds are strict: equal to the level must not set
  task automatic t_level;
    @(posedge clk) fifo_level_cfg <= 32'h0205_0005;
    tx_free_bytes <= 14'h00bf;
    tx_status_words <= 8'h05;
    rx_status_words <= 8'h05;
    @(posedge clk);
    look("lvl", 32'h0);
    @(posedge clk) tx_free_bytes <= 14'h00c0;
    tx_status_words <= 8'h06;
    rx_status_words <= 8'h06;
    @(posedge clk) tx_free_bytes <= 14'h0000;
    tx_status_words <= 8'h00;
    rx_status_words <= 8'h00;
    see("lvl", 32'h0000_0288);
  endtask
  task automatic t_line;
    @(posedge clk) ev <= 32'h1 << 18;
    @(posedge clk);
    u_host.wr(ISC_STATUS_OFS, 32'hffff_ffff);
    look("line", 32'h1 << 18);
    hit(32'h0);
    look("line", 32'h0);
  endtask
  task automatic t_irq;
    @(posedge clk) int_enable <= 32'h0002_0000;
    hit(32'h0002_0040);
    @(negedge clk);
    chk("irq", 32'h1, master_irq);
    chk("pme", 32'h1, power_event_irq);
    chk("wake", 32'h0, device_wake);
    u_host.wr(ISC_STATUS_OFS, 32'h0002_0000);
    look("rec", 32'h40);
    chk("irq", 32'h0, master_irq);
    chk("pme", 32'h0, power_event_irq);
    @(posedge clk) int_enable <= 32'h40;
    @(negedge clk);
    chk("irq", 32'h1, master_irq);
    u_host.wr(ISC_BYTE_TEST_OFS, 32'h0);
    @(negedge clk);
    chk("wake", 32'h1, device_wake);
    @(negedge clk);
    chk("wake", 32'h0, device_wake);
    fork
      u_host.wr(ISC_STATUS_OFS, 32'h40);
      hit(32'h40);
    join
    look("race", 32'h40);
    u_host.rd(8'h5c, d);
    chk("unmap", 32'h0, d);
    u_host.wr(8'h5c, 32'hffff_ffff);
    look("unmap", 32'h40);
    see("race", 32'h40);
    @(posedge clk) int_enable <= 32'h0000_2000;
    hit(32'h1 << 13);
    @(negedge clk);
    chk("irq", 32'h1, master_irq);
    see("txe", 32'h1 << 13);
  endtask
  initial begin
    sys_rst = 1'b1;
    {ev, int_enable, fifo_level_cfg, tx_free_bytes, tx_status_words,
      rx_status_words, rx_frame_len, rx_drop_count, timer_value} = '0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    look("reset", 32'h0);
    t_bits;
    t_cond;
    t_count;
    t_level;
    t_line;
    t_irq;
    test_done;
  end
  // cut a hang short well beyond the expected run length
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 6000) begin
      n_mismatch++;
      test_done;
    end
  end
endmodule
`default_nettype wire
